// ### inc/mcu_map_pkg.sv
// Address map constants for the program memory and register file decoder.
// Assumes a single clock domain and 8-bit byte storage behind both buses.
package mcu_map_pkg;
  // Bus widths
  localparam int PROG_AW = 12;
  localparam int REG_AW  = 8;
  localparam int WORK_W  = 4;

  // Program memory map
  localparam logic [11:0] PROG_TOP    = 12'h0FFF;
  localparam logic [11:0] VEC_HI_ADDR = 12'h0000;
  localparam logic [11:0] VEC_LO_ADDR = 12'h0001;
  localparam logic [11:0] ORDINARY_LO = 12'h0002;
  localparam logic [11:0] ORDINARY_HI = 12'h00FF;
  localparam logic [11:0] OPT_UNUSED0 = 12'h003C;
  localparam logic [11:0] OPT_UNUSED1 = 12'h003D;
  localparam logic [11:0] OPT_CFG0    = 12'h003E;
  localparam logic [11:0] OPT_CFG1    = 12'h003F;
  localparam logic [11:0] RESET_ENTRY = 12'h0100;

  // Option byte decode
  localparam logic [7:0] OPT_UNPROG  = 8'hFF;
  localparam int         LOW_VOLT_RESET_BIT = 7;
  localparam logic [1:0] OSC_INT_RC  = 2'h3;

  // Register file map
  localparam logic [7:0] GP_LO         = 8'h00;
  localparam logic [7:0] GP_HI         = 8'hBF;
  localparam logic [7:0] WORK_LO       = 8'hC0;
  localparam logic [7:0] WORK_HI       = 8'hCF;
  localparam logic [7:0] SYS_LO        = 8'hD0;
  localparam logic [7:0] SYS_IMPL_END  = 8'hDA;
  localparam logic [7:0] PERI_LO       = 8'hE0;
  localparam logic [7:0] PERI_IMPL_END = 8'hEE;

  // Region codes
  localparam logic [1:0] REGION_GP   = 2'h0;
  localparam logic [1:0] REGION_WORK = 2'h1;
  localparam logic [1:0] REGION_SYS  = 2'h2;
  localparam logic [1:0] REGION_PERI = 2'h3;

  // Start-up sequencer states
  typedef enum logic [5:0] {
    ST_VEC0 = 6'h01,
    ST_VEC1 = 6'h02,
    ST_CFG0 = 6'h04,
    ST_CFG1 = 6'h08,
    ST_LAST = 6'h10,
    ST_RUN  = 6'h20
  } boot_state_t;
endpackage : mcu_map_pkg

// ### inc/mem_port_if.sv
// Single byte-wide port between the decoder and a storage array.
// Assumes the array registers its read data on every clock edge.
`timescale 1ns/1ps
`default_nettype none
interface mem_port_if #(parameter int AW = 8) ();
  logic          we;
  logic [AW-1:0] addr;
  logic [7:0]    wdata;
  logic [7:0]    rdata;

  modport user  (output we, output addr, output wdata, input rdata);
  modport store (input we, input addr, input wdata, output rdata);
endinterface : mem_port_if
`default_nettype wire

// ### hw/byte_store.sv
// Byte-wide storage array with registered read data.
// Assumes one port; contents start erased and are not cleared by reset.
`timescale 1ns/1ps
`default_nettype none
module byte_store #(
  parameter int AW = 8
) (
  input  wire logic   clk_sys,
  input  wire logic   resetn,
  mem_port_if.store   port
);
  // Erased cells read as all ones until written
  logic [7:0] mem_q [2**AW] = '{default: 8'hFF};

  // Write port
  always_ff @(posedge clk_sys) begin
    if (port.we) begin
      mem_q[port.addr] <= port.wdata;
    end
  end

  // Registered read, cleared at reset only
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      port.rdata <= 8'h00;
    end else begin
      port.rdata <= mem_q[port.addr];
    end
  end
endmodule : byte_store
`default_nettype wire

// ### hw/mcu_address_space_map.sv
// Program memory and register file address decoder with start-up option load.
// Assumes the core drives fetch and register requests synchronous to clk_sys.
`timescale 1ns/1ps
`default_nettype none
module mcu_address_space_map
  import mcu_map_pkg::*;
(
  input  wire logic                       clk_sys,
  input  wire logic                       resetn,
  input  wire logic                       prog_load_we,
  input  wire logic [mcu_map_pkg::PROG_AW-1:0] prog_load_addr,
  input  wire logic [7:0]                 prog_load_data,
  input  wire logic                       prog_fetch,
  input  wire logic [mcu_map_pkg::PROG_AW-1:0] prog_addr,
  output logic                            prog_ready,
  output logic [7:0]                      prog_rdata,
  output logic                            prog_rvalid,
  input  wire logic                       reg_re,
  input  wire logic                       reg_we,
  input  wire logic                       reg_pair,
  input  wire logic                       reg_work_mode,
  input  wire logic [mcu_map_pkg::REG_AW-1:0] reg_addr,
  input  wire logic [15:0]                reg_wdata,
  output logic                            reg_ready,
  output logic [15:0]                     reg_rdata,
  output logic                            reg_rvalid,
  output logic [1:0]                      reg_region,
  output logic                            reg_addr_invalid,
  output logic                            boot_done,
  output logic [mcu_map_pkg::PROG_AW-1:0] reset_entry_addr,
  output logic [15:0]                     int_vector_addr,
  output logic [7:0]                      opt_cfg0,
  output logic [7:0]                      opt_cfg1,
  output logic                            low_voltage_reset_en,
  output logic                            osc_internal_rc
);
  import mcu_map_pkg::*;

  boot_state_t  state_reg;
  logic [7:0]   vec_hi_reg;
  logic [7:0]   vec_lo_reg;
  logic [7:0]   cfg0_reg;
  logic [7:0]   cfg1_reg;
  logic         fetch_take;
  logic         run;
  logic [7:0]   req_addr;
  logic         req_take;
  logic         wr_take;
  logic         rd_take;
  logic         full_work_bad;
  logic         pair_ph_reg;
  logic         pair_wr_reg;
  logic [7:0]   pair_base_reg;
  logic [7:0]   pair_lsb_reg;
  logic         s1_rd_reg;
  logic         s1_keep_reg;
  logic         s1_msb_reg;
  logic         s1_pairlo_reg;
  logic [7:0]   msb_hold_reg;
  logic [7:0]   masked;

  mem_port_if #(.AW(PROG_AW)) pm_if ();
  mem_port_if #(.AW(REG_AW))  rm_if ();

  // Program memory and register storage arrays
  byte_store #(.AW(PROG_AW)) u_prog_store (
    .clk_sys (clk_sys),
    .resetn  (resetn),
    .port    (pm_if.store)
  );
  byte_store #(.AW(REG_AW)) u_reg_store (
    .clk_sys (clk_sys),
    .resetn  (resetn),
    .port    (rm_if.store)
  );

  // Implemented locations; single page, plain 8-bit address
  function automatic logic impl_loc(input logic [7:0] a);
    impl_loc = (a <= WORK_HI) ||
               (a >= SYS_LO && a <= SYS_IMPL_END) ||
               (a >= PERI_LO && a <= PERI_IMPL_END);
  endfunction : impl_loc

  // Region of a register address
  function automatic logic [1:0] region_of(input logic [7:0] a);
    if (a <= GP_HI) begin
      region_of = REGION_GP;
    end else if (a <= WORK_HI) begin
      region_of = REGION_WORK;
    end else if (a < PERI_LO) begin
      region_of = REGION_SYS;
    end else begin
      region_of = REGION_PERI;
    end
  endfunction : region_of

  assign run = (state_reg == ST_RUN);

  // Start-up sequencer: vector then option bytes
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      state_reg <= ST_VEC0;
    end else begin
      case (state_reg)
        ST_VEC0: state_reg <= ST_VEC1;
        ST_VEC1: state_reg <= ST_CFG0;
        ST_CFG0: state_reg <= ST_CFG1;
        ST_CFG1: state_reg <= ST_LAST;
        ST_LAST: state_reg <= ST_RUN;
        ST_RUN:  state_reg <= ST_RUN;
        default: state_reg <= ST_VEC0;
      endcase
    end
  end

  // Capture bytes one cycle after each start-up read
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      vec_hi_reg <= 8'h00;
      vec_lo_reg <= 8'h00;
      cfg0_reg   <= OPT_UNPROG;
      cfg1_reg   <= OPT_UNPROG;
    end else begin
      case (state_reg)
        ST_VEC1: vec_hi_reg <= pm_if.rdata;
        ST_CFG0: vec_lo_reg <= pm_if.rdata;
        ST_CFG1: cfg0_reg   <= pm_if.rdata;
        ST_LAST: cfg1_reg   <= pm_if.rdata;
        default: ;
      endcase
    end
  end

  // Option decode; erased bytes give low-voltage reset and internal RC
  assign low_voltage_reset_en = cfg0_reg[LOW_VOLT_RESET_BIT];
  assign osc_internal_rc      = (cfg1_reg[1:0] == OSC_INT_RC);
  assign opt_cfg0             = cfg0_reg;
  assign opt_cfg1             = cfg1_reg;
  assign int_vector_addr      = {vec_hi_reg, vec_lo_reg};
  assign reset_entry_addr     = RESET_ENTRY;
  assign boot_done            = run;

  // Program port: sequencer, image load, or core fetch over 12 bits
  assign prog_ready = run && !prog_load_we;
  assign fetch_take = prog_fetch && prog_ready;
  always_comb begin
    pm_if.we    = 1'b0;
    pm_if.wdata = prog_load_data;
    pm_if.addr  = prog_addr;
    case (state_reg)
      ST_VEC0: pm_if.addr = VEC_HI_ADDR;
      ST_VEC1: pm_if.addr = VEC_LO_ADDR;
      ST_CFG0: pm_if.addr = OPT_CFG0;
      ST_CFG1: pm_if.addr = OPT_CFG1;
      ST_RUN: begin
        if (prog_load_we) begin
          pm_if.we   = 1'b1;
          pm_if.addr = prog_load_addr;
        end
      end
      default: ;
    endcase
  end

  // Fetch data valid one cycle after the request is taken
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      prog_rvalid <= 1'b0;
    end else begin
      prog_rvalid <= fetch_take;
    end
  end
  assign prog_rdata = pm_if.rdata;

  // Register request decode on the separate 8-bit bus
  assign req_addr = reg_work_mode ? {WORK_LO[7:4], reg_addr[WORK_W-1:0]} : reg_addr;
  assign full_work_bad = !reg_work_mode && (reg_addr >= WORK_LO) && (reg_addr <= WORK_HI);
  assign reg_ready = run && !pair_ph_reg;
  assign req_take  = (reg_re || reg_we) && reg_ready;
  assign wr_take   = req_take && reg_we;
  assign rd_take   = req_take && !reg_we;

  // Register port: pair high byte at even address, low byte next cycle
  always_comb begin
    rm_if.we    = 1'b0;
    rm_if.addr  = req_addr;
    rm_if.wdata = reg_wdata[7:0];
    if (pair_ph_reg) begin
      rm_if.addr  = {pair_base_reg[7:1], 1'b1};
      rm_if.wdata = pair_lsb_reg;
      rm_if.we    = pair_wr_reg && impl_loc({pair_base_reg[7:1], 1'b1});
    end else if (req_take && reg_pair) begin
      rm_if.addr  = {req_addr[7:1], 1'b0};
      rm_if.wdata = reg_wdata[15:8];
      rm_if.we    = wr_take && !full_work_bad && impl_loc({req_addr[7:1], 1'b0});
    end else if (req_take) begin
      rm_if.we    = wr_take && !full_work_bad && impl_loc(req_addr);
    end
  end

  // Pair second phase bookkeeping
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      pair_ph_reg   <= 1'b0;
      pair_wr_reg   <= 1'b0;
      pair_base_reg <= 8'h00;
      pair_lsb_reg  <= 8'h00;
    end else begin
      pair_ph_reg <= req_take && reg_pair;
      if (req_take) begin
        pair_wr_reg   <= reg_we;
        pair_base_reg <= full_work_bad ? PERI_IMPL_END : req_addr;      // Invalid form reads as zero
        pair_lsb_reg  <= reg_wdata[7:0];
      end
    end
  end

  // Read pipeline stage aligned with array data
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      s1_rd_reg     <= 1'b0;
      s1_keep_reg   <= 1'b0;
      s1_msb_reg    <= 1'b0;
      s1_pairlo_reg <= 1'b0;
    end else begin
      s1_rd_reg     <= (rd_take && !reg_pair) || (pair_ph_reg && !pair_wr_reg);
      s1_msb_reg    <= rd_take && reg_pair;
      s1_pairlo_reg <= pair_ph_reg && !pair_wr_reg;
      s1_keep_reg   <= pair_ph_reg ? impl_loc({pair_base_reg[7:1], 1'b1}) :
                       (!full_work_bad && impl_loc(reg_pair ? {req_addr[7:1], 1'b0} : req_addr));
    end
  end
  assign masked = s1_keep_reg ? rm_if.rdata : 8'h00;

  // Read data out; pair result is {even byte, odd byte}
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      reg_rdata    <= 16'h0000;
      reg_rvalid   <= 1'b0;
      msb_hold_reg <= 8'h00;
    end else begin
      reg_rvalid <= s1_rd_reg;
      if (s1_msb_reg) begin
        msb_hold_reg <= masked;
      end
      if (s1_rd_reg) begin
        reg_rdata <= {(s1_pairlo_reg ? msb_hold_reg : 8'h00), masked};
      end
    end
  end

  // Region and invalid-form report for each taken request
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      reg_region       <= REGION_GP;
      reg_addr_invalid <= 1'b0;
    end else begin
      reg_addr_invalid <= req_take && full_work_bad;
      if (req_take) begin
        reg_region <= region_of(req_addr);
      end
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);

  sequence boot_vec_reads;
    (pm_if.addr == VEC_HI_ADDR) ##1 (pm_if.addr == VEC_LO_ADDR);
  endsequence
  sequence boot_cfg_reads;
    (pm_if.addr == OPT_CFG0) ##1 (pm_if.addr == OPT_CFG1);
  endsequence

  boot_order_a: assert property ((state_reg == ST_VEC0) |-> boot_vec_reads ##1 boot_cfg_reads ##2 boot_done)
    else $error("start-up read order wrong");
  vector_capture_a: assert property ($rose(boot_done) |->
      int_vector_addr == {$past(pm_if.rdata, 4), $past(pm_if.rdata, 3)})
    else $error("interrupt vector not taken from bytes 0 and 1");
  option_decode_a: assert property ($rose(boot_done) && $past(pm_if.rdata, 2) == OPT_UNPROG &&
      $past(pm_if.rdata, 1) == OPT_UNPROG |-> low_voltage_reset_en && osc_internal_rc)
    else $error("erased option bytes not decoded as defaults");
  entry_addr_a: assert property (boot_done |-> reset_entry_addr == RESET_ENTRY && prog_ready == !prog_load_we)
    else $error("reset entry address wrong");
  fetch_path_a: assert property (fetch_take |-> pm_if.addr == prog_addr && !pm_if.we ##1 prog_rvalid)
    else $error("fetch not served on program bus");
  unimpl_zero_a: assert property (rd_take && !reg_pair && !impl_loc(req_addr) |->
      !rm_if.we ##2 (reg_rvalid && reg_rdata == 16'h0000))
    else $error("unimplemented read not zero");
  unimpl_write_a: assert property (wr_take && !reg_pair && !impl_loc(req_addr) |-> !rm_if.we)
    else $error("unimplemented write not dropped");
  work_select_a: assert property (req_take && reg_work_mode && !reg_pair |->
      rm_if.addr == {WORK_LO[7:4], reg_addr[3:0]} ##1 reg_region == REGION_WORK)
    else $error("working register select wrong");
  invalid_form_a: assert property (req_take && full_work_bad |-> !rm_if.we ##1 reg_addr_invalid)
    else $error("full address into working area not refused");
  pair_order_a: assert property (wr_take && reg_pair |-> rm_if.addr[0] == 1'b0 &&
      rm_if.wdata == reg_wdata[15:8] ##1 (rm_if.addr[0] && rm_if.wdata == $past(reg_wdata[7:0]) && !reg_ready))
    else $error("pair byte order wrong");
  gp_region_a: assert property (req_take && reg_addr <= GP_HI && !reg_work_mode |-> ##1 reg_region == REGION_GP)
    else $error("general purpose region wrong");
endmodule : mcu_address_space_map
`default_nettype wire

// ### tb/core_model.sv
// Core-side model: issues image loads, fetches and register requests.
// Assumes the decoder takes requests on rising edges of clk_sys.
`timescale 1ns/1ps
`default_nettype none
module core_model
  import mcu_map_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        prog_ready,
  input  wire logic        reg_ready,
  input  wire logic        boot_done,
  output logic             prog_load_we,
  output logic [11:0]      prog_load_addr,
  output logic [7:0]       prog_load_data,
  output logic             prog_fetch,
  output logic [11:0]      prog_addr,
  output logic             reg_re,
  output logic             reg_we,
  output logic             reg_pair,
  output logic             reg_work_mode,
  output logic [7:0]       reg_addr,
  output logic [15:0]      reg_wdata
);
  // Quiet bus at time zero
  initial begin
    {prog_load_we, prog_fetch, reg_re, reg_we, reg_pair, reg_work_mode} = 6'h00;
    {prog_load_addr, prog_load_data, prog_addr, reg_addr, reg_wdata} = '0;
  end

  // Drops strobes, scrambles released lines
  task automatic idle();
    @(negedge clk_sys);
    {prog_load_we, prog_fetch, reg_re, reg_we} = 4'h0;
    prog_addr = ~prog_addr;
    reg_addr  = ~reg_addr;
    reg_wdata = ~reg_wdata;
  endtask : idle

  // Image byte, held until boot has finished
  task automatic load(input logic [11:0] a, input logic [7:0] d);
    @(negedge clk_sys);
    {prog_fetch, reg_re, reg_we} = 3'h0;
    prog_load_we   = 1'b1;
    prog_load_addr = a;
    prog_load_data = d;
    while (boot_done !== 1'b1) @(negedge clk_sys);
    @(posedge clk_sys);
  endtask : load

  // Program fetch on the 12-bit bus
  task automatic fetch(input logic [11:0] a);
    @(negedge clk_sys);
    {prog_load_we, reg_re, reg_we} = 3'h0;
    prog_fetch = 1'b1;
    prog_addr  = a;
    while (prog_ready !== 1'b1) @(negedge clk_sys);
    @(posedge clk_sys);
  endtask : fetch

  // Register request on the separate 8-bit bus, 4-bit field in work mode
  task automatic reg_op(input logic we, input logic pair, input logic work,
                        input logic [7:0] a, input logic [15:0] d);
    @(negedge clk_sys);
    {prog_load_we, prog_fetch} = 2'h0;
    reg_we        = we;
    reg_re        = !we;
    reg_pair      = pair;
    reg_work_mode = work;
    reg_addr      = a;
    reg_wdata     = d;
    while (reg_ready !== 1'b1) @(negedge clk_sys);
    @(posedge clk_sys);
  endtask : reg_op
endmodule : core_model
`default_nettype wire

// ### tb/mcu_address_space_map_tb_top.sv
// Self-checking bench for the address map decoder, with queued expectations.
// Assumes core_model drives all requests and storage is not cleared by reset.
`timescale 1ns/1ps
`default_nettype none
module mcu_address_space_map_tb_top;
  import mcu_map_pkg::*;
  logic clk_sys, resetn, prog_load_we, prog_fetch, reg_re, reg_we, reg_pair, reg_work_mode;
  logic prog_ready, prog_rvalid, reg_ready, reg_rvalid, reg_addr_invalid, boot_done;
  logic low_voltage_reset_en, osc_internal_rc, reg_take;
  logic [11:0] prog_load_addr, prog_addr, reset_entry_addr;
  logic [7:0]  prog_load_data, prog_rdata, reg_addr, opt_cfg0, opt_cfg1, shadow[256];
  logic [15:0] reg_wdata, reg_rdata, int_vector_addr, cfg_tab[3];
  logic [1:0]  reg_region;
  logic [7:0]  pq[$];
  logic [15:0] rq[$];
  logic [2:0]  gq[$];
  logic [7:0]  prog_img[int];
  int errors, n_compared, n;

  mcu_address_space_map mcu_address_space_map_inst (.clk_sys(clk_sys), .resetn(resetn),
    .prog_load_we(prog_load_we), .prog_load_addr(prog_load_addr), .prog_load_data(prog_load_data),
    .prog_fetch(prog_fetch), .prog_addr(prog_addr), .prog_ready(prog_ready), .prog_rdata(prog_rdata),
    .prog_rvalid(prog_rvalid), .reg_re(reg_re), .reg_we(reg_we), .reg_pair(reg_pair),
    .reg_work_mode(reg_work_mode), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_ready(reg_ready),
    .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .reg_region(reg_region),
    .reg_addr_invalid(reg_addr_invalid), .boot_done(boot_done), .reset_entry_addr(reset_entry_addr),
    .int_vector_addr(int_vector_addr), .opt_cfg0(opt_cfg0), .opt_cfg1(opt_cfg1),
    .low_voltage_reset_en(low_voltage_reset_en), .osc_internal_rc(osc_internal_rc));

  core_model core_model_inst (.clk_sys(clk_sys), .prog_ready(prog_ready), .reg_ready(reg_ready),
    .boot_done(boot_done), .prog_load_we(prog_load_we), .prog_load_addr(prog_load_addr),
    .prog_load_data(prog_load_data), .prog_fetch(prog_fetch), .prog_addr(prog_addr), .reg_re(reg_re),
    .reg_we(reg_we), .reg_pair(reg_pair), .reg_work_mode(reg_work_mode), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata));

  // 40 MHz clock
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end

  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp

  // Per-kind compares: fetch byte, register data, request class
  task automatic cmp_prog(input logic [7:0] got, input logic [7:0] exp);
    cmp({8'h00, got}, {8'h00, exp});
  endtask : cmp_prog
  task automatic cmp_reg(input logic [15:0] got, input logic [15:0] exp);
    cmp(got, exp);
  endtask : cmp_reg
  task automatic cmp_class(input logic [2:0] got, input logic [2:0] exp);
    cmp({13'h0000, got}, {13'h0000, exp});
  endtask : cmp_class

  task automatic test_done();
    if (errors == 0 && n_compared > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : test_done

  // Expected {invalid, region} of a request
  function automatic logic [2:0] reg_class(input logic [7:0] a, input logic work);
    if (work || (a >= 8'hC0 && a <= 8'hCF)) return {!work, 2'h1};
    if (a <= 8'hBF) return 3'h0;
    return (a <= 8'hDF) ? 3'h2 : 3'h3;
  endfunction : reg_class

  // Storage present at this address
  function automatic logic impl(input logic [7:0] a, input logic work);
    return work || a <= 8'hBF || (a >= 8'hD0 && a <= 8'hDA) || (a >= 8'hE0 && a <= 8'hEE);
  endfunction : impl

  // Register access with shadow bookkeeping
  task automatic rw(input logic we, input logic pair, input logic work, input logic [7:0] a,
                    input logic [15:0] d);
    logic [7:0] e;
    e = work ? {4'hC, a[3:0]} : {a[7:1], a[0] & !pair};
    gq.push_back(reg_class(e, work));
    if (we && impl(e, work)) shadow[e] = pair ? d[15:8] : d[7:0];
    if (we && pair && impl(e | 8'h01, 1'b0)) shadow[e | 8'h01] = d[7:0];
    if (!we && pair) rq.push_back({impl(e, 1'b0) ? shadow[e] : 8'h00, impl(e | 8'h01, 1'b0) ? shadow[e | 8'h01] : 8'h00});
    if (!we && !pair) rq.push_back({8'h00, impl(e, work) ? shadow[e] : 8'h00});
    core_model_inst.reg_op(we, pair, work, a, d);
  endtask : rw

  task automatic ld(input logic [11:0] a, input logic [7:0] d);
    prog_img[a] = d;
    core_model_inst.load(a, d);
  endtask : ld

  // Reset for 16 cycles, then time the start-up load
  task automatic do_reset();
    @(negedge clk_sys);
    resetn = 1'b0;
    repeat (16) @(negedge clk_sys);
    cmp({boot_done, reg_ready, prog_ready, low_voltage_reset_en, osc_internal_rc}, 16'h0003);
    cmp({opt_cfg0, opt_cfg1}, 16'hFFFF);
    resetn = 1'b1;
    for (n = 0; n < 50 && boot_done !== 1'b1; n++) @(negedge clk_sys);
    cmp(n[15:0], 16'd5);
    cmp({4'h0, reset_entry_addr}, 16'h0100);
  endtask : do_reset

  // Result watcher
  always @(posedge clk_sys) reg_take <= resetn && (reg_re || reg_we) && reg_ready;
  always @(negedge clk_sys) begin
    if (prog_rvalid === 1'b1) cmp_prog(prog_rdata, pq.size() ? pq.pop_front() : 'x);
    if (reg_rvalid === 1'b1) cmp_reg(reg_rdata, rq.size() ? rq.pop_front() : 'x);
    if (reg_take) cmp_class({reg_addr_invalid, reg_region}, gq.size() ? gq.pop_front() : 'x);
  end

  // Watchdog
  initial begin
    #(25 * 40000);
    errors++;
    test_done();
  end

  initial begin
    resetn = 1'b0;
    reg_take = 1'b0;
    cfg_tab = '{16'hFFFF, 16'hE703, 16'h6702};
    void'($urandom(2));
    do_reset();
    // Every full address written, then read back
    for (int i = 0; i < 256; i++) rw(1'b1, 1'b0, 1'b0, i[7:0], {8'h00, 8'($urandom)});
    for (int i = 0; i < 256; i++) rw(1'b0, 1'b0, 1'b0, i[7:0], 16'h0000);
    // Working registers through the 4-bit field, then full-address reads of the working area
    for (int i = 0; i < 16; i++) rw(1'b1, 1'b0, 1'b1, {4'($urandom), i[3:0]}, 16'($urandom));
    for (int i = 0; i < 16; i++) rw(1'b0, 1'b0, 1'b1, {4'($urandom), i[3:0]}, 16'h0000);
    for (int i = 0; i < 16; i++) rw(1'b0, 1'b0, 1'b0, {4'hC, i[3:0]}, 16'h0000);
    // Pairs, odd address forced even, one crossing into unimplemented space
    for (int i = 0; i < 12; i++) begin
      logic [7:0] a;
      a = (i == 0) ? 8'hDA : 8'($urandom % 192);
      rw(1'b1, 1'b1, 1'b0, a, 16'($urandom));
      rw(1'b0, 1'b1, 1'b0, a | 8'h01, 16'h0000);
    end
    // Random image bytes including the map edges
    foreach (cfg_tab[i]) ld(12'h002 << (i * 4), 8'($urandom));
    ld(12'h0FFF, 8'($urandom));
    for (int i = 0; i < 30; i++) ld(12'($urandom), 8'($urandom));
    // Vector and option bytes, then reboot
    foreach (cfg_tab[i]) begin
      logic [15:0] v;
      v = 16'($urandom);
      ld(12'h000, v[15:8]);
      ld(12'h001, v[7:0]);
      ld(12'h03C, 8'h00);
      ld(12'h03D, 8'h00);
      ld(12'h03E, cfg_tab[i][15:8]);
      ld(12'h03F, cfg_tab[i][7:0]);
      core_model_inst.idle();
      do_reset();
      cmp(int_vector_addr, v);
      cmp({opt_cfg0, opt_cfg1}, cfg_tab[i]);
      cmp({low_voltage_reset_en, osc_internal_rc}, {cfg_tab[i][15], cfg_tab[i][1:0] == 2'b11});
    end
    // Fetch back everything, back to back
    foreach (prog_img[a]) begin
      pq.push_back(prog_img[a]);
      core_model_inst.fetch(a[11:0]);
    end
    core_model_inst.idle();
    repeat (6) @(negedge clk_sys);
    cmp(16'(pq.size() + rq.size() + gq.size()), 16'h0000);
    test_done();
  end
endmodule : mcu_address_space_map_tb_top
`default_nettype wire
